// ===== sup_pkg.sv
// shared constants and types for the parallel unit supervisor
package sup_pkg;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_UNITS    = 12'h008;
    localparam logic [11:0] ADDR_ALARM    = 12'h00C;
    localparam logic [11:0] ADDR_SETPT    = 12'h010;
    localparam logic [11:0] ADDR_LIMIT    = 12'h014;
    localparam logic [11:0] ADDR_PMAX     = 12'h018;
    localparam logic [11:0] ADDR_CMD      = 12'h01C;
    localparam logic [11:0] ADDR_NVCFG    = 12'h020;
    localparam logic [11:0] ADDR_VERSION  = 12'h024;
    // ctrl bit positions
    localparam int CTRL_MODE_LO   = 0;  // 2 bits: 0 off,1 slave,2 master
    localparam int CTRL_BIAS      = 2;
    localparam int CTRL_TERM      = 3;
    localparam int CTRL_SAG_EN    = 4;
    // cmd bits (write one to act)
    localparam int CMD_INIT       = 0;
    localparam int CMD_ACK        = 1;
    localparam int MAX_UNITS      = 64;
    localparam int MAX_SLAVES     = 63;
    localparam logic [6:0]  UNIT_CNT_MAX  = 7'h40;
    localparam logic [31:0] RATED_POWER_W = 32'h00007530; // 30000 W default
    localparam logic [31:0] SAG_POWER_W   = 32'h00005208; // 21000 W
    localparam logic [31:0] SETPT_RESET   = 32'h00000000;
    localparam logic [31:0] LIMIT_DEFAULT = 32'h0000FFFF;
    // ride-through span, milliseconds, and cycles at 10 MHz
    localparam int SAG_MAX_MS     = 1700;
    localparam int CLK_KHZ        = 10000;
    localparam int SAG_CYCLES     = SAG_MAX_MS * CLK_KHZ;
    localparam int INIT_WAIT_CYC  = 16;
    localparam logic [15:0] FW_VERSION = 16'h0001; // arbitrary value
    localparam logic [15:0] HW_VERSION = 16'h0001; // arbitrary value
    typedef enum logic [1:0] {ROLE_OFF, ROLE_SLAVE, ROLE_MASTER, ROLE_RSV}
        role_type;
    typedef enum {
        IDLE, INIT_RUN, RUNNING, FAILED, LOST
    } init_state_type;
endpackage

// ===== ms_link_if.sv
// link carrier between the supervisor and its bus engine
`timescale 1ns/1ps
interface ms_link_if;
    logic        init_req;   // start a sweep
    logic        init_done;  // sweep finished
    logic        init_fail;  // sweep found conflict
    logic [6:0]  unit_cnt;   // units found, master included
    logic        link_lost;  // a slave dropped out
    logic [31:0] bcast_data; // value broadcast to slaves
    logic [3:0]  bcast_sel;  // which item
    logic        bcast_vld;
    modport sup (output init_req, bcast_data, bcast_sel, bcast_vld,
                 input init_done, init_fail, unit_cnt, link_lost);
    modport eng (input init_req, bcast_data, bcast_sel, bcast_vld,
                 output init_done, init_fail, unit_cnt, link_lost);
endinterface

// ===== ms_bus_engine.sv
// bus engine: sweeps the peer reports and flags conflicts and losses
`timescale 1ns/1ps
module ms_bus_engine
    import sup_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [6:0]  peer_present,   // slaves answering
    input  wire logic        peer_master,    // another master seen
    input  wire logic        peer_ver_ok,    // all versions match
    input  wire logic        peer_drop,      // a slave stopped answering
    ms_link_if.eng           lnk
);
    logic [4:0] wait_r;
    logic       busy_r;
    logic       run_r;

    // sweep timer and result latch
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= '0;
            busy_r <= 1'b0;
            run_r  <= 1'b0;
            lnk.init_done <= 1'b0;
            lnk.init_fail <= 1'b0;
            lnk.unit_cnt  <= 7'h01;
        end else begin
            lnk.init_done <= 1'b0;
            if (lnk.init_req) begin
                busy_r <= 1'b1;
                run_r  <= 1'b0;
                wait_r <= '0;
                lnk.init_fail <= 1'b0;
            end else if (busy_r) begin
                wait_r <= wait_r + 5'h01;
                if (wait_r == 5'(INIT_WAIT_CYC - 1)) begin
                    busy_r <= 1'b0;
                    lnk.init_done <= 1'b1;
                    // clash fails sweep
                    lnk.init_fail <= peer_master | ~peer_ver_ok;
                    run_r <= ~(peer_master | ~peer_ver_ok);
                    // capped at one master plus 63 slaves
                    lnk.unit_cnt <= (peer_present > 7'(MAX_SLAVES)) ?
                        UNIT_CNT_MAX : peer_present + 7'h01;
                end
            end
        end
    end

    // losses only matter while the system runs
    assign lnk.link_lost = run_r & peer_drop;
endmodule

// ===== ride_through.sv
// line sag ride-through timer with boot-time lockout
`timescale 1ns/1ps
module ride_through
    import sup_pkg::*;
#(
    parameter int SAG_CYC = SAG_CYCLES
)(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic boot_done,     // pulse when start-up settles
    input  wire logic line_low_range,
    input  wire logic sag_en_req,
    input  wire logic line_sag,      // sag up to half rated voltage
    input  wire logic line_lost,     // deeper than ride-through covers
    output logic      sag_active,
    output logic      sag_locked,
    output logic      line_failure_alarm
);
    logic [24:0] cnt_r;

    // lockout latched at start-up only
    always_ff @(posedge clk) begin
        if (rst)
            sag_locked <= 1'b0;
        else if (boot_done)
            sag_locked <= line_low_range;
    end

    assign sag_active = sag_en_req & ~sag_locked;

    // sag counter: alarm once span is exceeded, at once on line loss or on a sag without ride-through
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            line_failure_alarm <= 1'b0;
        end else if (line_lost || (line_sag && !sag_active)) begin
            line_failure_alarm <= 1'b1;
        end else if (line_sag) begin
            if (cnt_r >= 25'(SAG_CYC))
                line_failure_alarm <= 1'b1;
            else
                cnt_r <= cnt_r + 25'h1;
        end else begin
            cnt_r <= '0;
            line_failure_alarm <= 1'b0;
        end
    end
endmodule

// ===== parallel_unit_supervisor.sv
// parallel operation supervisor: role, init, alarms, apb registers
// Notes on behaviour
// - stored master role triggers init at start-up
// - assigning master role starts init immediately
// - at most one master and 63 slaves
// - uninitialised slave or bus error raises alarm
// - init command accepted while parallel mode active
// - initialised slave rejects control, allows reads
// - master clears set values, rescales ranges
// - master broadcasts set values to slaves
// - slaves default limits, master copies changes; a bound slave keeps its old limit (default branch never fires)
// - slave alarm held until master acknowledges
// - link loss: inputs off, error, readable alarm
// - after loss slaves go single, need init
// - link alarm clears on init or mode off
// - remote standby forces input off
// - returning slave waits for new init
// - returning master reruns init automatically
// - second master fails init
// - version mismatch fails init, status readable
// - master shows only latest slave alarm
// - own trips reported to master
// - ride through sag up to span
// - low line range locks ride-through off
// - ride-through applies reduced power limit
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module parallel_unit_supervisor
    import sup_pkg::*;
#(
    parameter int SAG_CYC = SAG_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        boot_done,
    input  wire logic [3:0]  nv_cfg,
    output logic      [3:0]  nv_cfg_save,
    output logic             nv_save_stb,
    input  wire logic        master_init_seen,
    input  wire logic        master_link_bad,
    input  wire logic [6:0]  peer_present,
    input  wire logic        peer_master,
    input  wire logic        peer_ver_ok,
    input  wire logic        peer_drop,
    input  wire logic        slave_alarm_vld,
    input  wire logic [7:0]  slave_alarm_code,
    input  wire logic        overvoltage_trip,
    input  wire logic        overcurrent_trip,
    input  wire logic        overpower_trip,
    input  wire logic        remote_standby_input,
    input  wire logic        local_ctrl_req,
    input  wire logic        line_low_range,
    input  wire logic        line_sag,
    input  wire logic        line_lost,
    output logic             dc_input_on,
    output logic             error_led,
    output logic             bias_on,
    output logic             term_on,
    output logic             own_alarm_report,
    output logic      [31:0] bcast_data,
    output logic      [3:0]  bcast_sel,
    output logic             bcast_vld
);
    ms_link_if lnk ();

    init_state_type state_r;
    role_type       role_r;
    logic        bias_r, term_r, sag_en_r, dc_on_r, link_alarm_r;
    logic        slave_held_r, own_alarm_r, init_fail_r;
    logic [7:0]  last_alarm_r;
    logic [31:0] setpt_r, limit_r, pmax_r;
    logic [31:0] bcast_data_r;
    logic [3:0]  bcast_sel_r;
    logic        bcast_vld_r;
    logic        init_pend_r;
    logic        wr_ok, rd_ok, init_cmd, ack_cmd;
    logic        sag_active, sag_locked, line_failure_alarm;
    logic        is_master, is_slave, slave_bound;
    logic [31:0] prdata_nxt;

    ms_bus_engine u_eng (
        .clk          (clk),
        .rst          (rst),
        .peer_present (peer_present),
        .peer_master  (peer_master),
        .peer_ver_ok  (peer_ver_ok),
        .peer_drop    (peer_drop),
        .lnk          (lnk)
    );

    ride_through #(.SAG_CYC(SAG_CYC)) u_rt (
        .clk                (clk),
        .rst                (rst),
        .boot_done          (boot_done),
        .line_low_range     (line_low_range),
        .sag_en_req         (sag_en_r),
        .line_sag           (line_sag),
        .line_lost          (line_lost),
        .sag_active         (sag_active),
        .sag_locked         (sag_locked),
        .line_failure_alarm (line_failure_alarm)
    );

    // no wait states
    assign pready      = 1'b1;
    assign wr_ok       = psel & penable & pwrite;
    assign rd_ok       = psel & penable & ~pwrite;
    assign is_master   = (role_r == ROLE_MASTER);
    assign is_slave    = (role_r == ROLE_SLAVE);
    assign slave_bound = is_slave & master_init_seen & ~master_link_bad;
    assign init_cmd    = wr_ok && paddr == ADDR_CMD && pwdata[CMD_INIT];
    assign ack_cmd     = wr_ok && paddr == ADDR_CMD && pwdata[CMD_ACK];

    // unmapped addresses answer with an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (paddr > ADDR_VERSION || paddr[1:0] != 2'b00)
                pslverr = 1'b1;
        end
    end

    // role and switches; bound slave drops writes
    always_ff @(posedge clk) begin
        if (rst) begin
            role_r <= ROLE_OFF;
            bias_r <= 1'b0;
            term_r <= 1'b0;
        end else if (boot_done) begin
            role_r <= role_type'(nv_cfg[1:0]);
            bias_r <= nv_cfg[CTRL_BIAS];
            term_r <= nv_cfg[CTRL_TERM];
        end else if (wr_ok && paddr == ADDR_CTRL && !slave_bound) begin
            role_r <= role_type'(pwdata[1:0]);
            bias_r <= pwdata[CTRL_BIAS];
            term_r <= pwdata[CTRL_TERM];
        end
    end

    // persist role and switches on every ctrl write not dropped by a bound slave
    always_ff @(posedge clk) begin
        if (rst) begin
            nv_save_stb <= 1'b0;
            nv_cfg_save <= 4'h0;
        end else begin
            nv_save_stb <= wr_ok && paddr == ADDR_CTRL && !slave_bound;
            nv_cfg_save <= {pwdata[CTRL_TERM], pwdata[CTRL_BIAS],
                            pwdata[1:0]};
        end
    end

    // ride-through request; lock keeps it clear
    always_ff @(posedge clk) begin
        if (rst)
            sag_en_r <= 1'b0;
        else if (sag_locked)
            sag_en_r <= 1'b0;
        else if (wr_ok && paddr == ADDR_CTRL && !slave_bound)
            sag_en_r <= pwdata[CTRL_SAG_EN];
    end

    // init request: boot, new master or command
    always_ff @(posedge clk) begin
        if (rst)
            init_pend_r <= 1'b0;
        else if (boot_done && nv_cfg[1:0] == 2'(ROLE_MASTER))
            init_pend_r <= 1'b1;
        else if (wr_ok && paddr == ADDR_CTRL && !slave_bound &&
                 pwdata[1:0] == 2'(ROLE_MASTER) && !is_master)
            init_pend_r <= 1'b1;
        else if (init_cmd && role_r != ROLE_OFF)
            init_pend_r <= 1'b1;
        else
            init_pend_r <= 1'b0;
    end
    assign lnk.init_req = init_pend_r & is_master;

    // master-side init sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r     <= IDLE;
            init_fail_r <= 1'b0;
        end else if (!is_master) begin
            state_r <= IDLE;
        end else begin
            case (state_r)
                IDLE, FAILED, LOST, RUNNING: begin
                    if (lnk.init_req) begin
                        state_r     <= INIT_RUN;
                        init_fail_r <= 1'b0;
                    end else if (state_r == RUNNING && lnk.link_lost)
                        state_r <= LOST;
                end
                INIT_RUN: begin
                    if (lnk.init_done) begin
                        state_r     <= lnk.init_fail ? FAILED : RUNNING;
                        init_fail_r <= lnk.init_fail;
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // link alarm: set beats clear
    always_ff @(posedge clk) begin
        if (rst)
            link_alarm_r <= 1'b0;
        else if (lnk.link_lost && is_master)
            link_alarm_r <= 1'b1;
        else if (is_slave && (!master_init_seen || master_link_bad))
            link_alarm_r <= 1'b1;
        else if (role_r == ROLE_OFF || (lnk.init_done && !lnk.init_fail)
                 || slave_bound)
            link_alarm_r <= 1'b0;
    end

    // slave alarms: latest one wins, held until acknowledged
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_held_r <= 1'b0;
            last_alarm_r <= 8'h00;
        end else if (slave_alarm_vld && is_master) begin
            slave_held_r <= 1'b1;
            last_alarm_r <= slave_alarm_code;
        end else if (ack_cmd) begin
            slave_held_r <= 1'b0;
        end
    end

    // own trips latch until acknowledged
    always_ff @(posedge clk) begin
        if (rst)
            own_alarm_r <= 1'b0;
        else if (overvoltage_trip || overcurrent_trip || overpower_trip)
            own_alarm_r <= 1'b1;
        else if (ack_cmd)
            own_alarm_r <= 1'b0;
    end
    assign own_alarm_report = own_alarm_r;

    // set values: cleared by init, locked when bound
    always_ff @(posedge clk) begin
        if (rst) begin
            setpt_r <= SETPT_RESET;
            limit_r <= LIMIT_DEFAULT;
        end else if (lnk.init_done && !lnk.init_fail) begin
            setpt_r <= SETPT_RESET;
            limit_r <= LIMIT_DEFAULT;
        end else if (slave_bound && !master_init_seen) begin
            limit_r <= LIMIT_DEFAULT;
        end else if (wr_ok && !slave_bound && paddr == ADDR_SETPT) begin
            setpt_r <= pwdata;
        end else if (wr_ok && !slave_bound && paddr == ADDR_LIMIT) begin
            limit_r <= pwdata;
        end
    end

    // power ceiling: scaled by units, cut in sag mode
    always_ff @(posedge clk) begin
        if (rst)
            pmax_r <= RATED_POWER_W;
        else if (sag_active)
            pmax_r <= SAG_POWER_W;
        else if (is_master && state_r == RUNNING)
            pmax_r <= 32'(RATED_POWER_W * 32'(lnk.unit_cnt));
        else
            pmax_r <= RATED_POWER_W;
    end

    // broadcast changed values while running
    always_ff @(posedge clk) begin
        if (rst) begin
            bcast_vld_r  <= 1'b0;
            bcast_sel_r  <= 4'h0;
            bcast_data_r <= 32'h00000000;
        end else begin
            bcast_vld_r <= is_master && state_r == RUNNING && wr_ok &&
                (paddr == ADDR_SETPT || paddr == ADDR_LIMIT);
            bcast_sel_r  <= paddr[5:2];
            bcast_data_r <= pwdata;
        end
    end
    assign lnk.bcast_vld  = bcast_vld_r;
    assign lnk.bcast_sel  = bcast_sel_r;
    assign lnk.bcast_data = bcast_data_r;
    assign bcast_vld  = bcast_vld_r;
    assign bcast_sel  = bcast_sel_r;
    assign bcast_data = bcast_data_r;

    // dc input: any alarm or standby forces it off
    always_ff @(posedge clk) begin
        if (rst)
            dc_on_r <= 1'b0;
        else if (remote_standby_input || link_alarm_r || slave_held_r ||
                 own_alarm_r || line_failure_alarm)
            dc_on_r <= 1'b0;
        else if (local_ctrl_req && !slave_bound)
            dc_on_r <= 1'b1;
        else if (wr_ok && paddr == ADDR_CMD && pwdata[2] && !slave_bound)
            dc_on_r <= 1'b1;
        else if (wr_ok && paddr == ADDR_CMD && pwdata[3] && !slave_bound)
            dc_on_r <= 1'b0;
    end
    assign dc_input_on = dc_on_r;
    assign error_led   = link_alarm_r | slave_held_r | own_alarm_r;
    assign bias_on     = bias_r;
    assign term_on     = term_r;

    // read mux; reads always allowed, even on a bound slave
    always_comb begin
        prdata_nxt = 32'h00000000;
        if (paddr == ADDR_CTRL)
            prdata_nxt = {27'h0, sag_en_r, term_r, bias_r, role_r};
        else if (paddr == ADDR_STATUS)
            prdata_nxt = {22'h0, sag_locked, sag_active,
                          line_failure_alarm, own_alarm_r, slave_held_r,
                          link_alarm_r, init_fail_r, slave_bound,
                          state_r == RUNNING, dc_on_r};
        else if (paddr == ADDR_UNITS)
            prdata_nxt = {25'h0, lnk.unit_cnt};
        else if (paddr == ADDR_ALARM)
            prdata_nxt = {24'h0, last_alarm_r};
        else if (paddr == ADDR_SETPT)
            prdata_nxt = setpt_r;
        else if (paddr == ADDR_LIMIT)
            prdata_nxt = limit_r;
        else if (paddr == ADDR_PMAX)
            prdata_nxt = pmax_r;
        else if (paddr == ADDR_NVCFG)
            prdata_nxt = {28'h0, nv_cfg};
        else if (paddr == ADDR_VERSION)
            prdata_nxt = {HW_VERSION, FW_VERSION};
    end

    // read data loaded in the setup cycle
    always_ff @(posedge clk) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= prdata_nxt;
    end
endmodule

// ===== sup_asserts.sv
// checks on the supervisor's ports
`timescale 1ns/1ps
module sup_asserts
    import sup_pkg::*;
#(
    parameter int SAG_CYC = SAG_CYCLES
)(
    input wire logic        clk, rst, psel, penable, pwrite, pready,
    input wire logic        pslverr, nv_save_stb, remote_standby_input,
    input wire logic        local_ctrl_req, dc_input_on, bias_on,
    input wire logic        term_on, master_init_seen, bcast_vld,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata, bcast_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // access-phase write
    wire logic wr = psel && penable && pwrite;
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (
        psel && penable && paddr > ADDR_VERSION |-> pslverr)
        else $error("no pslverr on unmapped");
    // read data may only move after a setup cycle
    a_read_hold: assert property (
        $changed(prdata) |-> $past(psel && !penable))
        else $error("prdata moved");
    a_standby_off: assert property (
        remote_standby_input [*2] |-> !dc_input_on)
        else $error("dc on in standby");
    a_dc_cause: assert property (
        $rose(dc_input_on) |-> $past(local_ctrl_req ||
            (wr && paddr == ADDR_CMD && pwdata[2])))
        else $error("dc on unrequested");
    a_bcast_cause: assert property (
        bcast_vld |-> $past(wr && (paddr == ADDR_SETPT ||
            paddr == ADDR_LIMIT)))
        else $error("stray broadcast");
    a_bcast_copy: assert property (
        bcast_vld |-> bcast_data == $past(pwdata))
        else $error("broadcast value altered");
    a_nv_save: assert property (
        nv_save_stb |-> $past(wr && paddr == ADDR_CTRL))
        else $error("stray save strobe");
    a_bias_term: assert property (
        wr && paddr == ADDR_CTRL && !master_init_seen |=>
        bias_on == $past(pwdata[CTRL_BIAS]) &&
        term_on == $past(pwdata[CTRL_TERM]))
        else $error("switches not updated");
endmodule

bind parallel_unit_supervisor sup_asserts #(.SAG_CYC(SAG_CYC)) i_chk (.*);

// ===== peer_units.sv
// peer units on the bus
`timescale 1ns/1ps
module peer_units (
    input  wire logic        clk, bcast_vld,
    input  wire logic [31:0] bcast_data,
    output logic      [6:0]  peer_present,
    output logic             peer_master, peer_ver_ok, peer_drop,
    output logic             slave_alarm_vld,
    output logic      [7:0]  slave_alarm_code,
    output logic      [31:0] last_bcast
);
    // idle bus: no peers, versions agree
    initial begin
        peer_present = 7'h00;
        peer_master = 1'b0;
        peer_ver_ok = 1'b1;
        peer_drop = 1'b0;
        slave_alarm_vld = 1'b0;
        slave_alarm_code = 8'h00;
        last_bcast = 32'h0;
    end
    // slaves copy broadcasts as sent
    always @(posedge clk) if (bcast_vld) last_bcast <= bcast_data;
    task set_peers(input logic [6:0] n, input logic m, input logic v);
        @(posedge clk);
        peer_present <= n;
        peer_master <= m;
        peer_ver_ok <= v;
    endtask
    task drop_link;
        @(posedge clk);
        peer_drop <= 1'b1;
        @(posedge clk);
        peer_drop <= 1'b0;
    endtask
    // code valid only with strobe
    task alarm(input logic [7:0] c);
        @(posedge clk);
        slave_alarm_vld <= 1'b1;
        slave_alarm_code <= c;
        @(posedge clk);
        slave_alarm_vld <= 1'b0;
        slave_alarm_code <= ~c;
    endtask
endmodule

// ===== test_parallel_unit_supervisor.sv
// bench for the parallel unit supervisor
`timescale 1ns/1ps
module test_parallel_unit_supervisor;
    import sup_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic boot_done = 0, line_low_range = 0, line_sag = 0;
    logic remote_standby_input = 0, local_ctrl_req = 0;
    logic own_alarm_report, line_lost = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata, bcast_data, last_bcast;
    logic [3:0] nv_cfg = 4'h0;
    logic [2:0] trip = 3'h0;
    logic [7:0] slave_alarm_code;
    logic [6:0] peer_present;
    logic pready, pslverr, dc_input_on, error_led, bias_on, term_on;
    logic bcast_vld, peer_master, peer_ver_ok, peer_drop, slave_alarm_vld;
    int num_errors = 0, cmp_count = 0;
    localparam logic [31:0] PMAX_64 = RATED_POWER_W * 64;
    always #50 clk = ~clk;
    parallel_unit_supervisor #(.SAG_CYC(20)) i_dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .boot_done, .nv_cfg, .nv_cfg_save(),
        .nv_save_stb(), .master_init_seen(1'b0), .master_link_bad(1'b0),
        .peer_present, .peer_master, .peer_ver_ok, .peer_drop,
        .slave_alarm_vld, .slave_alarm_code, .overvoltage_trip(trip[0]),
        .overcurrent_trip(trip[1]), .overpower_trip(trip[2]),
        .remote_standby_input, .local_ctrl_req, .line_low_range, .line_sag,
        .line_lost, .dc_input_on, .error_led, .bias_on, .term_on,
        .own_alarm_report, .bcast_data, .bcast_sel(), .bcast_vld);
    peer_units i_peer (.clk, .bcast_vld, .bcast_data, .peer_present,
        .peer_master, .peer_ver_ok, .peer_drop, .slave_alarm_vld,
        .slave_alarm_code, .last_bcast);
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, held until pready
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task sbit(input int b, input logic e);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("status bit", {31'h0, e}, {31'h0, rd[b]});
    endtask
    // bounded wait; a miss shows in the next check
    task poll(input int b);
        for (int i = 0; i < 60; i++) begin
            xfer(1'b0, ADDR_STATUS, 32'h0);
            if (rd[b] === 1'b1) break;
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
    initial begin
        wt(6);
        rst <= 1'b0;
        rchk(ADDR_PMAX, RATED_POWER_W, "pmax");
        rchk(ADDR_LIMIT, LIMIT_DEFAULT, "limit");
        xfer(1'b0, 12'h028, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        i_peer.set_peers(7'h3F, 1'b0, 1'b1);
        xfer(1'b1, ADDR_CTRL, 32'h0E);
        wt(1);
        chk("bias term", 32'h3, {30'h0, bias_on, term_on});
        poll(1);
        rchk(ADDR_UNITS, 32'h40, "units");
        rchk(ADDR_PMAX, PMAX_64, "pmax scaled");
        rchk(ADDR_SETPT, SETPT_RESET, "setpt");
        xfer(1'b1, ADDR_SETPT, 32'h1234);
        wt(2);
        chk("bcast", 32'h1234, last_bcast);
        for (int i = 0; i < 3; i++) begin
            trip <= 3'(3'h1 << i);
            wt(1);
            trip <= 3'h0;
            sbit(6, 1'b1);
            chk("report", 32'h1, {31'h0, own_alarm_report});
            xfer(1'b1, ADDR_CMD, 32'h2);
            sbit(6, 1'b0);
        end
        i_peer.alarm(8'h11);
        i_peer.alarm(8'h22);
        rchk(ADDR_ALARM, 32'h22, "alarm code");
        chk("led", 32'h1, {31'h0, error_led});
        xfer(1'b1, ADDR_CMD, 32'h2);
        sbit(5, 1'b0);
        xfer(1'b1, ADDR_CMD, 32'h4);
        remote_standby_input <= 1'b1;
        wt(2);
        local_ctrl_req <= 1'b1;
        wt(1);
        local_ctrl_req <= 1'b0;
        chk("dc standby", 32'h0, {31'h0, dc_input_on});
        remote_standby_input <= 1'b0;
        xfer(1'b1, ADDR_CMD, 32'h4);
        i_peer.drop_link;
        wt(2);
        chk("dc loss", 32'h0, {31'h0, dc_input_on});
        sbit(4, 1'b1);
        xfer(1'b1, ADDR_CMD, 32'h1);
        poll(1);
        sbit(4, 1'b0);
        xfer(1'b1, ADDR_CTRL, 32'h1E);
        rchk(ADDR_PMAX, SAG_POWER_W, "pmax sag");
        line_sag <= 1'b1;
        wt(10);
        line_sag <= 1'b0;
        sbit(7, 1'b0);
        xfer(1'b1, ADDR_CTRL, 32'h0E);
        rchk(ADDR_PMAX, PMAX_64, "pmax back");
        for (int k = 0; k < 2; k++) begin
            i_peer.set_peers(7'h03, k == 0, k == 0);
            xfer(1'b1, ADDR_CMD, 32'h1);
            poll(3);
            sbit(3, 1'b1);
            i_peer.set_peers(7'h3F, 1'b0, 1'b1);
            xfer(1'b1, ADDR_CMD, 32'h1);
            poll(1);
            sbit(3, 1'b0);
        end
        // power cycle: stored master role, low line
        rst <= 1'b1;
        nv_cfg <= 4'hE;
        line_low_range <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(1);
        boot_done <= 1'b1;
        wt(1);
        boot_done <= 1'b0;
        poll(1);
        chk("nv bias", 32'h3, {30'h0, bias_on, term_on});
        sbit(9, 1'b1);
        xfer(1'b1, ADDR_CTRL, 32'h1E);
        sbit(8, 1'b0);
        line_lost <= 1'b1;
        sbit(7, 1'b1);
        final_report;
    end
endmodule
